// File: hw/smsp_pkg.sv
// Constants, types and codes shared by the SMBus slave register port.
// Assumes a single 200 MHz system clock; bus pins are asynchronous to it.
`default_nettype none
package smsp_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int unsigned NUM_REGS = 9;
	localparam logic [7:0] REG_LAST_RO = 8'h07;
	localparam logic [7:0] REG_CFG_IDX = 8'h05;
	localparam logic [7:0] REG_ADJ_IDX = 8'h08;
	localparam logic [7:0] CFG_WR_MASK = 8'hC0;
	localparam logic [7:0] ADJ_WR_MASK = 8'h7F;
	localparam logic [1:0] CFG_RST = 2'h0;
	localparam logic [6:0] ADJ_RST = 7'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [7:0] PTR_RST = 8'h00;

	// ****************************************
	// Slave addresses and strap
	// ****************************************
	localparam logic [6:0] ADDR_GND = 7'h2C;
	localparam logic [6:0] ADDR_OPEN = 7'h2E;
	localparam logic [6:0] ADDR_VDD = 7'h2F;
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_VDD = 2'h2;
	localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

	// ****************************************
	// Serial framing
	// ****************************************
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_IGNORE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} smsp_state_e;

endpackage
`default_nettype wire

// File: hw/smsp_regbank.sv
// Nine-register bank of the slave port with a registered read port.
// Assumes one write pulse per byte from the serial engine on the same clock.
`timescale 1ns/10ps
`default_nettype none
module smsp_regbank (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Host write port
	input wire logic wr_en,
	input wire logic [7:0] wr_idx,
	input wire logic [7:0] wr_data,
	// Host read port
	input wire logic [7:0] rd_idx,
	output logic [7:0] rd_data,
	// Internal status, byte n at bits 8n+7..8n
	input wire logic [63:0] stat_in,
	// Control outputs
	output logic [1:0] str_unused,
	output logic [6:0] peak_adj
);
	import smsp_pkg::*;

	logic [1:0] cfg_r;
	logic [6:0] adj_r;
	logic [7:0] rd_r;
	logic [7:0] rd_nxt;

	// ****************************************
	// Writable registers
	// ****************************************
	// Only the two writable fields have storage, so a write to any other index has nowhere to land
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_r <= CFG_RST;
			adj_r <= ADJ_RST;
		end else if (wr_en) begin
			if (wr_idx == REG_CFG_IDX) begin
				cfg_r <= wr_data[7:6];
			end
			if (wr_idx == REG_ADJ_IDX) begin
				adj_r <= wr_data[6:0];
			end
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rd_nxt = RD_UNMAPPED;
		if (rd_idx <= REG_LAST_RO) begin
			rd_nxt = stat_in[{rd_idx[2:0], 3'h0} +: 8];
		end
		if (rd_idx == REG_CFG_IDX) begin
			rd_nxt = {cfg_r, rd_nxt[5:0]};
		end
		if (rd_idx == REG_ADJ_IDX) begin
			rd_nxt = {1'b0, adj_r} & ADJ_WR_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_r <= RD_UNMAPPED;
		end else begin
			rd_r <= rd_nxt;
		end
	end

	assign rd_data = rd_r;
	assign str_unused = cfg_r;
	assign peak_adj = adj_r;

	// ****************************************
	// Checks
	// ****************************************
	property p_adj_write;
		@(posedge clk) disable iff (sys_rst)
		wr_en && wr_idx == REG_ADJ_IDX |=> peak_adj == $past(wr_data[6:0]);
	endproperty
	a_adj_write: assert property (p_adj_write) else $error("adjust register missed a write");

	property p_ro_write;
		@(posedge clk) disable iff (sys_rst)
		wr_en && wr_idx != REG_CFG_IDX && wr_idx != REG_ADJ_IDX |=> $stable(str_unused) && $stable(peak_adj);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

	property p_reserved_zero;
		@(posedge clk) disable iff (sys_rst)
		$past(rd_idx) == REG_ADJ_IDX |-> rd_data[7] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one");

	property p_unmapped;
		@(posedge clk) disable iff (sys_rst)
		rd_idx >= 8'(NUM_REGS) |=> rd_data == RD_UNMAPPED;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("index past the bank read nonzero");

endmodule
`default_nettype wire

// File: hw/smsp_port.sv
// SMBus / I2C slave engine reaching the nine-register bank.
// Assumes scl_in, sda_in and adr_sel are asynchronous pins; the SDA wire is resolved outside from sda_oe.
`timescale 1ns/10ps
`default_nettype none
module smsp_port (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Address strap, smsp_pkg::STRAP_* codes
	input wire logic [1:0] adr_sel,
	// Internal status bytes for registers 0 to 7
	input wire logic [63:0] stat_in,
	// Control outputs
	output logic [1:0] str_unused,
	output logic [6:0] peak_adj
);
	import smsp_pkg::*;

	smsp_state_e state_r;
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic [1:0] adr_m_r;
	logic [1:0] adr_q_r;
	logic [1:0] strap_cnt_r;
	logic strap_done_r;
	logic [6:0] my_addr_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] ptr_r;
	logic rw_r;
	logic nack_r;
	logic oe_r;
	logic [7:0] rd_data;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic addr_match;
	logic wr_en;

	// ****************************************
	// Pin synchronisers and edge detect
	// ****************************************
	// Bit 0 is the metastable stage; edges are found between bits 1 and 2 only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			adr_m_r <= STRAP_GND;
			adr_q_r <= STRAP_GND;
		end else begin
			scl_s_r <= {scl_s_r[1:0], scl_in};
			sda_s_r <= {sda_s_r[1:0], sda_in};
			adr_m_r <= adr_sel;
			adr_q_r <= adr_m_r;
		end
	end

	assign scl_rise = scl_s_r[1] && !scl_s_r[2];
	assign scl_fall = !scl_s_r[1] && scl_s_r[2];
	assign start_cond = scl_s_r[1] && scl_s_r[2] && !sda_s_r[1] && sda_s_r[2];
	assign stop_cond = scl_s_r[1] && scl_s_r[2] && sda_s_r[1] && !sda_s_r[2];
	assign byte_done = cnt_r == BITS_PER_BYTE;
	assign addr_match = strap_done_r && sh_r[7:1] == my_addr_r;

	// ****************************************
	// Address strap capture
	// ****************************************
	// Caught once after the synchroniser has filled; later strap movement is ignored until reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strap_cnt_r <= 2'h0;
			strap_done_r <= 1'b0;
			my_addr_r <= ADDR_GND;
		end else if (!strap_done_r) begin
			if (strap_cnt_r == STRAP_WAIT_CYC) begin
				strap_done_r <= 1'b1;
				unique case (adr_q_r)
					STRAP_OPEN: my_addr_r <= ADDR_OPEN;
					STRAP_VDD: my_addr_r <= ADDR_VDD;
					default: my_addr_r <= ADDR_GND;
				endcase
			end else begin
				strap_cnt_r <= strap_cnt_r + 2'h1;
			end
		end
	end

	// ****************************************
	// Transaction state
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else if (start_cond) begin
			state_r <= ST_ADDR;
		end else if (stop_cond) begin
			state_r <= ST_IDLE;
		end else if (scl_fall) begin
			unique case (state_r)
				ST_IDLE, ST_IGNORE: state_r <= state_r;
				ST_ADDR: if (byte_done) begin
					state_r <= addr_match ? ST_ADDR_ACK : ST_IGNORE;
				end
				ST_ADDR_ACK: state_r <= rw_r ? ST_RDATA : ST_CMD;
				ST_CMD: if (byte_done) begin
					state_r <= ST_CMD_ACK;
				end
				ST_CMD_ACK: state_r <= ST_WDATA;
				ST_WDATA: if (byte_done) begin
					state_r <= ST_WDATA_ACK;
				end
				ST_WDATA_ACK: state_r <= ST_WDATA;
				ST_RDATA: if (byte_done) begin
					state_r <= ST_RACK;
				end
				ST_RACK: state_r <= nack_r ? ST_IGNORE : ST_RDATA;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Bit counter and shifter
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
		end else if (start_cond) begin
			cnt_r <= 4'h0;
		end else if (scl_rise) begin
			if (state_r inside {ST_ADDR, ST_CMD, ST_WDATA}) begin
				cnt_r <= cnt_r + 4'h1;
				sh_r <= {sh_r[6:0], sda_s_r[1]};
			end else if (state_r == ST_RDATA) begin
				cnt_r <= cnt_r + 4'h1;
			end
		end else if (scl_fall) begin
			if ((state_r == ST_ADDR_ACK && rw_r) || (state_r == ST_RACK && !nack_r)) begin
				sh_r <= rd_data;
				cnt_r <= 4'h0;
			end else if (state_r == ST_RDATA && !byte_done) begin
				sh_r <= {sh_r[6:0], 1'b0};
			end else if (state_r inside {ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK}) begin
				cnt_r <= 4'h0;
			end
		end
	end

	// ****************************************
	// Direction flag, host acknowledge
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rw_r <= 1'b0;
			nack_r <= 1'b1;
		end else begin
			if (scl_fall && state_r == ST_ADDR && byte_done) begin
				rw_r <= sh_r[0];
			end
			if (scl_rise && state_r == ST_RACK) begin
				nack_r <= sda_s_r[1];
			end
		end
	end

	// ****************************************
	// Register pointer
	// ****************************************
	// Auto-increment after each data byte gives the word forms of read and write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ptr_r <= PTR_RST;
		end else if (scl_fall && byte_done) begin
			if (state_r == ST_CMD) begin
				ptr_r <= sh_r;
			end else if (state_r inside {ST_WDATA, ST_RDATA}) begin
				ptr_r <= ptr_r + 8'h01;
			end
		end
	end

	assign wr_en = scl_fall && state_r == ST_WDATA && byte_done;

	// ****************************************
	// SDA drive
	// ****************************************
	// Changes on SCL falling edges, about three clocks late, well inside the low period; START or STOP clears it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oe_r <= 1'b0;
		end else if (start_cond || stop_cond) begin
			oe_r <= 1'b0;
		end else if (scl_fall) begin
			unique case (state_r)
				ST_ADDR: oe_r <= byte_done && addr_match;
				ST_CMD, ST_WDATA: oe_r <= byte_done;
				ST_ADDR_ACK: oe_r <= rw_r && !rd_data[7];
				ST_RACK: oe_r <= !nack_r && !rd_data[7];
				ST_RDATA: oe_r <= !byte_done && !sh_r[6];
				default: oe_r <= 1'b0;
			endcase
		end
	end

	assign sda_oe = oe_r;
	assign sda_out = 1'b0;

	// ****************************************
	// Register bank
	// ****************************************
	smsp_regbank u_bank (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(wr_en),
		.wr_idx(ptr_r),
		.wr_data(sh_r),
		.rd_idx(ptr_r),
		.rd_data(rd_data),
		.stat_in(stat_in),
		.str_unused(str_unused),
		.peak_adj(peak_adj)
	);

	// ****************************************
	// Checks
	// ****************************************
	sequence s_addr_miss;
		scl_fall && state_r == ST_ADDR && byte_done && !addr_match;
	endsequence

	property p_miss_ignores;
		@(posedge clk) disable iff (sys_rst)
		s_addr_miss |=> state_r == ST_IGNORE && !sda_oe;
	endproperty
	a_miss_ignores: assert property (p_miss_ignores) else $error("address miss not ignored");

	property p_ignore_holds;
		@(posedge clk) disable iff (sys_rst)
		state_r == ST_IGNORE && !start_cond && !stop_cond |=> state_r == ST_IGNORE;
	endproperty
	a_ignore_holds: assert property (p_ignore_holds) else $error("left ignore without start");

	property p_idle_quiet;
		@(posedge clk) disable iff (sys_rst)
		state_r inside {ST_IDLE, ST_IGNORE, ST_ADDR} |-> !sda_oe && !wr_en;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("unaddressed port touched the bus");

	property p_strap_map;
		@(posedge clk) disable iff (sys_rst)
		$rose(strap_done_r) |-> my_addr_r == ($past(adr_q_r) == STRAP_OPEN ? ADDR_OPEN :
			$past(adr_q_r) == STRAP_VDD ? ADDR_VDD : ADDR_GND);
	endproperty
	a_strap_map: assert property (p_strap_map) else $error("strap decoded to wrong address");

	property p_cmd_ptr;
		@(posedge clk) disable iff (sys_rst)
		scl_fall && state_r == ST_CMD && byte_done |=> ptr_r == $past(sh_r) && sda_oe;
	endproperty
	a_cmd_ptr: assert property (p_cmd_ptr) else $error("command code not taken as pointer");

endmodule
`default_nettype wire

// File: bench/smsp_host.sv
// Host master model for the slave port: START, STOP, byte write and byte read.
// Assumes a pull-up on SDA; the bench resolves the wire from sda_low and the port's enable.
`timescale 1ns/10ps
`default_nettype none
module smsp_host (
	// Bus pins
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// Quarter of the 80 ns link period
	localparam time Q = 20ns;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ****************************************
	// Framing
	// ****************************************
	// Waits a quarter first so SDA never moves while the slave still sees SCL high
	// Pins move by non-blocking assignment on system clock edges, so the synchronisers never race them
	task automatic start();
		#Q sda_low <= 1'b0;
		#Q scl <= 1'b1;
		#Q sda_low <= 1'b1;
		#Q scl <= 1'b0;
	endtask

	// SCL then stands still high until the next frame
	task automatic stop();
		#Q sda_low <= 1'b1;
		#Q scl <= 1'b1;
		#Q sda_low <= 1'b0;
		#(4 * Q);
	endtask

	// ****************************************
	// Bits and bytes
	// ****************************************
	task automatic bit_xfer(input logic b, output logic r);
		#Q sda_low <= ~b;
		#Q scl <= 1'b1;
		#Q r = sda;
		#Q scl <= 1'b0;
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
		end
		bit_xfer(1'b1, ack);
	endtask

	// Last byte of a read is refused so the port lets go of SDA
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, d[i]);
		end
		bit_xfer(last, r);
	endtask
endmodule
`default_nettype wire

// File: bench/smsp_port_tb_top.sv
// Self-checking bench for the slave port, with a register model built from integers and queues.
// Assumes the host model drives the bus pins; registers are reached only through bus frames.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module smsp_port_tb_top;
	import smsp_pkg::*;
	logic clk, sys_rst, sda_in, sda_out, sda_oe, scl, host_low;
	logic [1:0] adr_sel, str_unused, cfg_m;
	logic [6:0] peak_adj, adj_m, addr;
	logic [63:0] stat_in;
	logic [6:0] addr_tab [4] = '{7'h2C, 7'h2E, 7'h2F, 7'h2C};
	int err_total, n_compared, ptr;

	// ****************************************
	// Design, host and wire
	// ****************************************
	assign sda_in = ~sda_oe & ~host_low;
	smsp_port i_smsp_port (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .adr_sel(adr_sel), .stat_in(stat_in), .str_unused(str_unused), .peak_adj(peak_adj));
	smsp_host i_smsp_host (.scl(scl), .sda_low(host_low), .sda(sda_in));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************
	// Model and tasks
	// ****************************************
	function automatic logic [7:0] exp_rd(input int i);
		if (i == 5) return {cfg_m, stat_in[45:40]};
		if (i == 8) return {1'b0, adj_m};
		if (i < 8) return stat_in[8 * i +: 8];
		return 8'h00;
	endfunction

	task automatic do_reset(input logic [1:0] s);
		@(posedge clk);
		sys_rst <= 1'b1;
		adr_sel <= s;
		stat_in <= {$urandom, $urandom};
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (12) @(posedge clk);
		cfg_m = 2'h0;
		adj_m = 7'h00;
		ptr = 0;
	endtask

	task automatic send_addr(input logic rw);
		logic a;
		i_smsp_host.start();
		i_smsp_host.wbyte({addr, rw}, a);
		`CHK("addr ack", 1'b0, a)
	endtask

	task automatic wr(input logic [7:0] idx, input int n);
		logic a;
		logic [7:0] q[$];
		send_addr(1'b0);
		i_smsp_host.wbyte(idx, a);
		`CHK("cmd ack", 1'b0, a)
		ptr = idx;
		for (int k = 0; k < n; k++) begin
			q.push_back(8'($urandom));
		end
		foreach (q[k]) begin
			i_smsp_host.wbyte(q[k], a);
			`CHK("data ack", 1'b0, a)
			if (ptr == 5) cfg_m = q[k][7:6];
			if (ptr == 8) adj_m = q[k][6:0];
			ptr = (ptr + 1) % 256;
		end
		i_smsp_host.stop();
		`CHK("str_unused", cfg_m, str_unused)
		`CHK("peak_adj", adj_m, peak_adj)
	endtask

	// Without a command this is a Receive Byte from the current pointer
	task automatic rd(input logic [7:0] idx, input int n, input logic cmd);
		logic a;
		logic [7:0] d;
		if (cmd) begin
			send_addr(1'b0);
			i_smsp_host.wbyte(idx, a);
			`CHK("cmd ack", 1'b0, a)
			ptr = idx;
		end
		send_addr(1'b1);
		for (int k = 0; k < n; k++) begin
			i_smsp_host.rbyte(k == n - 1, d);
			`CHK("read data", exp_rd(ptr), d)
			ptr = (ptr + 1) % 256;
		end
		i_smsp_host.stop();
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic a;
		sys_rst = 1'b1;
		adr_sel = 2'h0;
		stat_in = 64'h0;
		err_total = 0;
		n_compared = 0;
		void'($urandom(32'h993ca74e));
		// Every strap code, each after its own reset since the strap is caught once
		for (int s = 0; s < 4; s++) begin
			do_reset(s[1:0]);
			addr = addr_tab[s];
			`CHK("sda_out", 1'b0, sda_out)
			`CHK("peak_adj reset", 7'h00, peak_adj)
			`CHK("str_unused reset", 2'h0, str_unused)
			rd(8'h00, 1, 1'b0);
			// Another strap's address: no acknowledge and the write that follows is ignored
			i_smsp_host.start();
			i_smsp_host.wbyte({addr_tab[(s + 1) % 3], 1'b0}, a);
			`CHK("foreign ack", 1'b1, a)
			i_smsp_host.wbyte(8'h08, a);
			i_smsp_host.wbyte(8'($urandom), a);
			`CHK("ignored ack", 1'b1, a)
			i_smsp_host.stop();
			`CHK("peak_adj kept", 7'h00, peak_adj)
			wr(8'h08, 1);
			wr(8'h05, 2);
			wr(8'h02, 1);
			wr(8'h03, 0);
			rd(8'h00, 1, 1'b0);
			rd(8'h00, 10, 1'b1);
			rd(8'hFF, 2, 1'b1);
		end
		stop_test();
	end

	initial begin
		#300us;
		err_total++;
		$display("ERROR watchdog expected end seen hang");
		stop_test();
	end
endmodule
`default_nettype wire
